// >>> pkg/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
  // =====================================================================
  // Host bus widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 17;
  localparam int MEM_AW = 16;               // Word address width of the 128K byte block
  localparam int MEM_WORDS = 65536;
  // Control registers sit in the top 32 bytes of the block
  localparam logic [ADDR_W-1:0] REG_BASE = 17'h1ffe0;
  localparam int REG_WORDS = 16;
  localparam logic [3:0] REG_IDX_W0 = 4'h0;
  // Strap codes on mode bits 2..0
  localparam logic [2:0] CODE_PROC_A   = 3'h0;
  localparam logic [2:0] CODE_PROC_B   = 3'h1;
  localparam logic [2:0] CODE_ASTROBE1 = 3'h3;
  localparam logic [2:0] CODE_ASTROBE2 = 3'h5;
  localparam logic [2:0] CODE_BYTESTB  = 3'h7;
  // Decoded host bus modes
  typedef enum logic [2:0] {
    MODE_RESERVED  = 3'h0,
    MODE_PROC_A    = 3'h1,
    MODE_PROC_B    = 3'h2,
    MODE_ASTROBE1  = 3'h3,
    MODE_ASTROBE2  = 3'h4,
    MODE_BYTESTB1  = 3'h5,
    MODE_BYTESTB2  = 3'h6
  } bus_mode_t;
  // Cycles the refresh side may hold the port in arbitration
  localparam logic [3:0] REFRESH_SLOT_CYCLES = 4'h3;
endpackage
`default_nettype wire

// >>> hw/refresh_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module refresh_arbiter
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Requests
  input  wire logic refresh_req,
  input  wire logic host_req,
  // Grant
  output logic      host_grant
);
  typedef struct packed {
    logic [3:0] busy_cnt;
    logic       grant;
  } arb_state_t;
  arb_state_t st_reg;
  arb_state_t st_next;

  // =====================================================================
  // Refresh owns the memory for a slot; host granted when idle
  always_comb
  begin
    st_next = st_reg;
    st_next.grant = 1'b0;
    if (st_reg.busy_cnt != 4'h0)
      st_next.busy_cnt = st_reg.busy_cnt - 4'h1;
    else if (refresh_req)
      st_next.busy_cnt = REFRESH_SLOT_CYCLES;
    else if (host_req)
      st_next.grant = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign host_grant = st_reg.grant;
endmodule
`default_nettype wire

// >>> hw/lcd_host_bus_interface.sv
`timescale 1ns/100ps
`default_nettype none
module lcd_host_bus_interface
  import host_port_pkg::*;
(
  // Clock and reset (mclk is the host bus clock)
  input  wire logic                           mclk,
  input  wire logic                           rst_b,
  // Straps
  input  wire logic                           strap_mode_bit0,
  input  wire logic                           strap_mode_bit1,
  input  wire logic                           strap_mode_bit2,
  input  wire logic                           strap_endian,
  // Host bus
  input  wire logic                           chip_select_n,
  input  wire logic                           bus_status_n,
  input  wire logic [host_port_pkg::ADDR_W-1:0] host_address_in,
  input  wire logic                           low_byte_write_enable_n,
  input  wire logic                           high_byte_write_enable_n,
  input  wire logic                           low_byte_read_enable_n,
  input  wire logic                           read_write_dir,
  input  wire logic [host_port_pkg::DATA_W-1:0] host_data_in,
  output logic      [host_port_pkg::DATA_W-1:0] host_data_out,
  output logic      [1:0]                     host_data_oe,
  output logic                                wait_out_n,
  output logic                                wait_oe,
  // Display side
  input  wire logic                           refresh_req,
  output logic                                big_endian,
  output logic      [2:0]                     bus_mode
);
  import host_port_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARB  = 3'b010,
    ST_DONE = 3'b100
  } cyc_t;

  typedef struct packed {
    logic                  strap_taken;
    logic                  endian;
    bus_mode_t             mode;
    cyc_t                  cyc;
    logic                  is_write;
    logic [1:0]            lanes;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     dout;
    logic [1:0]            oe;
    logic                  wait_n;
    logic                  wait_en;
  } port_state_t;

  port_state_t st_reg;
  port_state_t st_next;

  logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
  logic [DATA_W-1:0] regs [0:REG_WORDS-1];
  logic              host_grant;
  logic              host_req;
  logic              astrobe;
  logic              req_go;
  logic              req_write;
  logic [1:0]        req_lanes;
  logic              is_reg;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_word;
  logic [2:0]        code;

  // =====================================================================
  // Arbitration against display refresh
  refresh_arbiter u_arb (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .refresh_req (refresh_req),
    .host_req    (host_req),
    .host_grant  (host_grant)
  );

  assign host_req = (st_reg.cyc == ST_ARB);
  assign code = {strap_mode_bit2, strap_mode_bit1, strap_mode_bit0};
  assign astrobe = (st_reg.mode == MODE_ASTROBE1) || (st_reg.mode == MODE_ASTROBE2);
  assign is_reg = (st_reg.addr >= REG_BASE);

  // Request decode per mode
  always_comb
  begin
    if (astrobe)
    begin
      // Strobes: address pin 0 low lane, high write enable upper lane
      req_lanes = {~high_byte_write_enable_n, ~host_address_in[0]};
      req_write = ~read_write_dir;
      req_go = ~chip_select_n & ~bus_status_n & (|req_lanes);
    end
    else
    begin
      req_write = ~low_byte_write_enable_n | ~high_byte_write_enable_n;
      req_lanes = req_write ? {~high_byte_write_enable_n, ~low_byte_write_enable_n}
                            : {~read_write_dir, ~low_byte_read_enable_n};
      req_go = ~chip_select_n & (|req_lanes);
    end
  end

  // Byte swap for big-endian hosts
  assign rd_word = is_reg ? regs[st_reg.addr[4:1]] : mem[st_reg.addr[ADDR_W-1:1]];
  assign wr_word = st_reg.endian ? {st_reg.wdata[7:0], st_reg.wdata[15:8]}
                                 : st_reg.wdata;

  // =====================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    if (!st_reg.strap_taken)
    begin
      // First edge after reset release latches the straps
      st_next.strap_taken = 1'b1;
      st_next.endian = strap_endian;
      case (code)
        CODE_PROC_A:   st_next.mode = MODE_PROC_A;
        CODE_PROC_B:   st_next.mode = MODE_PROC_B;
        CODE_ASTROBE1: st_next.mode = MODE_ASTROBE1;
        CODE_ASTROBE2: st_next.mode = MODE_ASTROBE2;
        CODE_BYTESTB:  st_next.mode = bus_status_n ? MODE_BYTESTB2 : MODE_BYTESTB1;
        default:       st_next.mode = MODE_RESERVED;
      endcase
    end
    st_next.wait_en = ~chip_select_n;
    case (st_reg.cyc)
      ST_IDLE:
      begin
        st_next.wait_n = 1'b1;
        st_next.oe = 2'b00;
        if (st_reg.strap_taken && req_go && st_reg.mode != MODE_RESERVED)
        begin
          st_next.cyc = ST_ARB;
          st_next.wait_n = 1'b0;
          st_next.is_write = req_write;
          st_next.lanes = req_lanes;
          st_next.addr = {host_address_in[ADDR_W-1:1], 1'b0};
          st_next.wdata = host_data_in;
        end
      end
      ST_ARB:
      begin
        st_next.wait_n = 1'b0;
        if (host_grant)
        begin
          st_next.cyc = ST_DONE;
          st_next.wait_n = 1'b1;
          if (!st_reg.is_write)
          begin
            st_next.dout = st_reg.endian ? {rd_word[7:0], rd_word[15:8]} : rd_word;
            st_next.oe = st_reg.lanes;
          end
        end
      end
      ST_DONE:
      begin
        // Hold data until the host drops its strobes
        if (!req_go || chip_select_n)
        begin
          st_next.cyc = ST_IDLE;
          st_next.oe = 2'b00;
        end
      end
      default: st_next.cyc = ST_IDLE;
    endcase
  end

  // =====================================================================
  // State register, timed by the host bus clock
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.cyc <= ST_IDLE;
      st_reg.mode <= MODE_RESERVED;
      st_reg.wait_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Storage writes, only enabled lanes
  always_ff @(posedge mclk)
  begin
    if (st_reg.cyc == ST_ARB && host_grant && st_reg.is_write)
    begin
      if (is_reg)
      begin
        if (st_reg.lanes[0]) regs[st_reg.addr[4:1]][7:0] <= wr_word[7:0];
        if (st_reg.lanes[1]) regs[st_reg.addr[4:1]][15:8] <= wr_word[15:8];
      end
      else
      begin
        if (st_reg.lanes[0]) mem[st_reg.addr[ADDR_W-1:1]][7:0] <= wr_word[7:0];
        if (st_reg.lanes[1]) mem[st_reg.addr[ADDR_W-1:1]][15:8] <= wr_word[15:8];
      end
    end
  end

  // Outputs
  assign host_data_out = st_reg.dout;
  assign host_data_oe = st_reg.oe;
  assign wait_out_n = st_reg.wait_n;
  assign wait_oe = st_reg.wait_en;
  assign big_endian = st_reg.endian;
  assign bus_mode = st_reg.mode;

  // =====================================================================
  // Checks
  sequence s_grant_seen;
    st_reg.cyc == ST_ARB && host_grant;
  endsequence

  a_wait_on_request: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.cyc == ST_IDLE && st_next.cyc == ST_ARB |=> !wait_out_n)
    else $error("wait not asserted at cycle start");
  a_wait_release: assert property (@(posedge mclk) disable iff (!rst_b)
    s_grant_seen |=> wait_out_n && st_reg.cyc == ST_DONE)
    else $error("wait not released after grant");
  a_wait_arb_low: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.cyc == ST_ARB |-> !wait_out_n)
    else $error("wait released during arbitration");
  a_read_lanes: assert property (@(posedge mclk) disable iff (!rst_b)
    s_grant_seen ##0 !st_reg.is_write |=> host_data_oe == $past(st_reg.lanes))
    else $error("read lanes wrong");
  a_write_no_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    s_grant_seen ##0 st_reg.is_write |=> host_data_oe == 2'b00)
    else $error("data driven on write");
  a_wait_cs: assert property (@(posedge mclk) disable iff (!rst_b)
    chip_select_n |=> !wait_oe)
    else $error("wait driven without chip select");
  a_strap_endian: assert property (@(posedge mclk) disable iff (!rst_b)
    !st_reg.strap_taken |=> big_endian == $past(strap_endian))
    else $error("endian strap not captured");
  a_strap_stable: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.strap_taken |=> $stable(bus_mode) && $stable(big_endian))
    else $error("strap values changed after capture");
endmodule
`default_nettype wire

// >>> tb/host_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host processor model
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock and configuration
  input  wire logic                               mclk,
  input  wire logic                               astb,
  input  wire logic                               bs_strap,
  // Bus drive
  output logic                                    chip_select_n,
  output logic                                    bus_status_n,
  output logic [host_port_pkg::ADDR_W-1:0]        host_address_in,
  output logic                                    low_byte_write_enable_n,
  output logic                                    high_byte_write_enable_n,
  output logic                                    low_byte_read_enable_n,
  output logic                                    read_write_dir,
  output logic [host_port_pkg::DATA_W-1:0]        host_data_in,
  // Device answer
  input  wire logic [host_port_pkg::DATA_W-1:0]   host_data_out,
  input  wire logic [1:0]                         host_data_oe,
  input  wire logic                               wait_out_n,
  input  wire logic                               wait_oe
);
  logic as_n;
  logic ack_line;

  // Pull-up holds acknowledge while the device lets go of it
  assign ack_line = wait_oe ? wait_out_n : 1'b1;

  // Status pin held low while bs_strap is low, else follows the address strobe
  assign bus_status_n = bs_strap & as_n;

  // Idle bus, data line turned over so stale values never match
  task automatic release_bus();
    chip_select_n = 1'b1;
    as_n = 1'b1;
    host_address_in[0] = 1'b1;
    low_byte_write_enable_n = 1'b1;
    high_byte_write_enable_n = 1'b1;
    low_byte_read_enable_n = 1'b1;
    read_write_dir = 1'b1;
    host_data_in = ~host_data_in;
  endtask

  // One bus cycle, held until acknowledge is sampled low then high, or 40 clocks pass
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [1:0] ln,
                      output logic [DATA_W-1:0] q, output logic [1:0] oe,
                      output logic ok, output int lat);
    logic seen_low;
    seen_low = 1'b0;
    ok = 1'b0;
    lat = 0;
    @(negedge mclk);
    chip_select_n = 1'b0;
    host_address_in = a;
    if (!rd)
      host_data_in = d;
    if (astb)
    begin
      as_n = 1'b0;
      host_address_in[0] = ~ln[0];
      high_byte_write_enable_n = ~ln[1];
      read_write_dir = rd;
    end
    else
    begin
      low_byte_write_enable_n = ~(ln[0] & ~rd);
      high_byte_write_enable_n = ~(ln[1] & ~rd);
      low_byte_read_enable_n = ~(ln[0] & rd);
      read_write_dir = ~(ln[1] & rd);
    end
    while (!ok && lat < 40)
    begin
      @(posedge mclk);
      #1;
      lat++;
      ok = seen_low && (ack_line === 1'b1);
      seen_low |= (ack_line === 1'b0);
    end
    q = host_data_out;
    oe = host_data_oe;
    @(negedge mclk);
    release_bus();
  endtask

  // Bus starts idle
  initial
  begin
    host_address_in = '0;
    host_data_in = '0;
    release_bus();
  end
endmodule
`default_nettype wire

// >>> tb/lcd_host_bus_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Testbench top
module lcd_host_bus_interface_tb_top;
  import host_port_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_b = 1'b0;
  logic [2:0]        strap = 3'h7;
  logic              strap_endian = 1'b0;
  logic              bs_strap = 1'b0;
  logic              astb = 1'b0;
  logic              refresh_req = 1'b0;
  wire               cs_n, bs_n, lwe_n, hwe_n, lre_n, dir, wait_n, wait_oe, big_endian;
  wire [ADDR_W-1:0]  adr;
  wire [DATA_W-1:0]  din, dout;
  wire [1:0]         doe;
  wire [2:0]         bus_mode;
  int                err_count = 0;
  int                samples_checked = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  lcd_host_bus_interface uut (.mclk(mclk), .rst_b(rst_b), .strap_mode_bit0(strap[0]),
    .strap_mode_bit1(strap[1]), .strap_mode_bit2(strap[2]), .strap_endian(strap_endian),
    .chip_select_n(cs_n), .bus_status_n(bs_n), .host_address_in(adr),
    .low_byte_write_enable_n(lwe_n), .high_byte_write_enable_n(hwe_n),
    .low_byte_read_enable_n(lre_n), .read_write_dir(dir), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(doe), .wait_out_n(wait_n), .wait_oe(wait_oe),
    .refresh_req(refresh_req), .big_endian(big_endian), .bus_mode(bus_mode));

  host_cpu_model host (.mclk(mclk), .astb(astb), .bs_strap(bs_strap), .chip_select_n(cs_n),
    .bus_status_n(bs_n), .host_address_in(adr), .low_byte_write_enable_n(lwe_n),
    .high_byte_write_enable_n(hwe_n), .low_byte_read_enable_n(lre_n),
    .read_write_dir(dir), .host_data_in(din), .host_data_out(dout),
    .host_data_oe(doe), .wait_out_n(wait_n), .wait_oe(wait_oe));

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected mode for a strap code
  function automatic bus_mode_t exp_mode(input logic [2:0] c, input logic bs);
    case (c)
      3'h0: return MODE_PROC_A;
      3'h1: return MODE_PROC_B;
      3'h3: return MODE_ASTROBE1;
      3'h5: return MODE_ASTROBE2;
      3'h7: return bs ? MODE_BYTESTB2 : MODE_BYTESTB1;
      default: return MODE_RESERVED;
    endcase
  endfunction

  // Reset with straps applied
  task automatic do_reset(input logic [2:0] c, input logic bs, input logic e);
    @(negedge mclk);
    rst_b = 1'b0;
    strap = c;
    bs_strap = bs;
    strap_endian = e;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
  endtask

  // Full write, lane write, full and lane read back
  task automatic burst(input int cnt, input bit full);
    logic [16:0] a;
    logic [15:0] d, d2, q, e, m;
    logic [1:0]  ln, oe;
    logic        ok;
    int          lat;
    for (int i = 0; i < cnt; i++)
    begin
      a = (i == 0) ? REG_BASE : 17'($urandom_range(0, 32'h1ffdf) & 32'h1fffe);
      d = 16'($urandom);
      d2 = 16'($urandom);
      ln = full ? 2'h3 : 2'($urandom_range(1, 3));
      host.xfer(1'b0, a, d, 2'h3, q, oe, ok, lat);
      chk("write_ack", ok, 1'b1);
      if (ok !== 1'b1)
        results();
      refresh_req = $urandom_range(0, 1);
      @(negedge mclk);
      refresh_req = 1'b0;
      host.xfer(1'b0, a, d2, ln, q, oe, ok, lat);
      chk("lane_write_ack", ok, 1'b1);
      e = {ln[1] ? d2[15:8] : d[15:8], ln[0] ? d2[7:0] : d[7:0]};
      host.xfer(1'b1, a, '0, 2'h3, q, oe, ok, lat);
      chk("read_data", q, e);
      chk("read_lanes", oe, 2'h3);
      chk("read_ack", ok, 1'b1);
      chk("ack_latency", 17'(lat), 17'h3);
      host.xfer(1'b1, a, '0, ln, q, oe, ok, lat);
      m = {{8{ln[1]}}, {8{ln[0]}}};
      chk("lane_read_oe", oe, ln);
      chk("lane_read_data", q & m, e & m);
      @(negedge mclk);
      chk("idle_wait_oe", wait_oe, 1'b0);
    end
  endtask

  // Main sequence
  initial
  begin
    logic [15:0] q;
    logic [1:0]  oe;
    logic        ok;
    logic        e;
    logic [15:0] wd;
    int          lat;
    void'($urandom(32'h5a3bcc39));
    for (int c = 0; c < 16; c++)
    begin
      e = 1'($urandom_range(0, 1));
      do_reset(c[3:1], c[0], e);
      chk("bus_mode", bus_mode, exp_mode(c[3:1], c[0]));
      chk("big_endian", big_endian, e);
      chk("wait_oe", wait_oe, 1'b0);
      if (exp_mode(c[3:1], c[0]) == MODE_RESERVED)
      begin
        host.xfer(1'b1, 17'h0, '0, 2'h3, q, oe, ok, lat);
        chk("reserved_refused", ok, 1'b0);
      end
    end
    $display("test strap_decode done");
    do_reset(3'h7, 1'b0, 1'b0);
    burst(12, 1'b0);
    $display("test byte_strobe_little done");
    do_reset(3'h7, 1'b0, 1'b1);
    burst(6, 1'b1);
    $display("test byte_strobe_big done");
    // Word written big-endian reads back byte-swapped once little-endian
    wd = 16'($urandom);
    host.xfer(1'b0, 17'h00010, wd, 2'h3, q, oe, ok, lat);
    chk("swap_write_ack", ok, 1'b1);
    do_reset(3'h7, 1'b0, 1'b0);
    host.xfer(1'b1, 17'h00010, '0, 2'h3, q, oe, ok, lat);
    chk("endian_swap", q, {1'b0, wd[7:0], wd[15:8]});
    $display("test endian_swap done");
    astb = 1'b1;
    do_reset(3'h3, 1'b1, 1'b0);
    burst(12, 1'b0);
    $display("test address_strobe done");
    results();
  end
endmodule
`default_nettype wire
